// >>> core/qmac_pkg.sv
package qmac_pkg;

    // ------------------------------------------------------------
    // Widths and field positions
    // ------------------------------------------------------------
    localparam int QMAC_WORD_W = 32;
    localparam int QMAC_HALF_W = 16;
    localparam int QMAC_ACC_W = 64;
    localparam int QMAC_NUM_ACC = 4;
    localparam int QMAC_SEL_W = 2;
    localparam int QMAC_FLAG_LSB = 16;
    localparam int QMAC_FLAG_MSB = 19;
    localparam int QMAC_LEFT_LSB = 16;
    localparam int QMAC_RIGHT_LSB = 0;
    localparam int QMAC_Q31_HI = 62;
    localparam int QMAC_Q31_LO = 31;

    // ------------------------------------------------------------
    // Special values and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] QMAC_Q15_MINUS_ONE = 16'h8000;
    localparam logic [31:0] QMAC_Q31_MAX = 32'h7fffffff;
    localparam logic [63:0] QMAC_ACC_POS_MAX = 64'h000000007fffffff;
    localparam logic [63:0] QMAC_ACC_NEG_MIN = 64'hffffffff80000000;
    localparam logic [31:0] QMAC_MASK_ZERO = 32'h00000000;
    localparam logic [31:0] QMAC_MASK_ONES = 32'hffffffff;
    localparam logic [31:0] QMAC_CTRL_RESET = 32'h00000000;
    localparam logic [63:0] QMAC_ACC_RESET = 64'h0000000000000000;

    // ------------------------------------------------------------
    // Operations and carriers
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        QMAC_LEFT_PRODUCT_SAT,
        QMAC_LEFT_FULL_SAT,
        QMAC_RIGHT_PRODUCT_SAT,
        QMAC_RIGHT_FULL_SAT
    } qmac_op_e;

    typedef struct packed {
        logic valid;
        qmac_op_e op;
        logic [1:0] accumulator_select;
        logic [31:0] src_s;
        logic [31:0] src_t;
    } qmac_req_s;

    typedef struct packed {
        logic reserved_instr;
        logic signal_proc_disabled;
    } qmac_exc_s;

endpackage : qmac_pkg

// >>> core/qmac_product.sv
`timescale 1ns/10ps
`default_nettype none
module qmac_product (
    // Selected halfwords
    input wire logic [qmac_pkg::QMAC_HALF_W-1:0] half_s,
    input wire logic [qmac_pkg::QMAC_HALF_W-1:0] half_t,
    // Product
    output logic [qmac_pkg::QMAC_WORD_W-1:0] product,
    output logic product_sat
);
    import qmac_pkg::*;

    logic signed [31:0] raw;

    always_comb begin
        raw = $signed(half_s) * $signed(half_t);
        product_sat = (half_s == QMAC_Q15_MINUS_ONE)
            && (half_t == QMAC_Q15_MINUS_ONE);
        if (product_sat) begin
            product = QMAC_Q31_MAX;
        end else begin
            product = {raw[30:0], 1'b0};
        end
    end
endmodule : qmac_product
`default_nettype wire

// >>> core/qmac_unit.sv
`timescale 1ns/10ps
`default_nettype none
module qmac_unit (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Issue from the pipeline
    input wire qmac_pkg::qmac_req_s req,
    input wire logic signal_proc_enable,
    input wire logic opcode_reserved,
    // Results
    output logic done,
    output qmac_pkg::qmac_exc_s exc,
    output logic [qmac_pkg::QMAC_WORD_W-1:0] signal_proc_control_reg,
    output logic [qmac_pkg::QMAC_WORD_W-1:0] accumulator_high_word [4],
    output logic [qmac_pkg::QMAC_WORD_W-1:0] accumulator_low_word [4]
);
    import qmac_pkg::*;

    // ------------------------------------------------------------
    // Operation decode functions
    // ------------------------------------------------------------

    function automatic logic op_is_left(input qmac_op_e op);
        op_is_left = (op == QMAC_LEFT_PRODUCT_SAT)
            || (op == QMAC_LEFT_FULL_SAT);
    endfunction : op_is_left

    function automatic logic op_is_full(input qmac_op_e op);
        op_is_full = (op == QMAC_LEFT_FULL_SAT)
            || (op == QMAC_RIGHT_FULL_SAT);
    endfunction : op_is_full

    function automatic logic [15:0] pick_half(input logic [31:0] word,
        input logic left);
        if (left) begin
            pick_half = word[QMAC_LEFT_LSB +: QMAC_HALF_W];
        end else begin
            pick_half = word[QMAC_RIGHT_LSB +: QMAC_HALF_W];
        end
    endfunction : pick_half

    function automatic logic [3:0] acc_mask(input logic [1:0] sel);
        acc_mask = 4'h1 << sel;
    endfunction : acc_mask

    function automatic logic issue_accepted(input logic valid,
        input logic reserved, input logic enable);
        issue_accepted = valid && !reserved && enable;
    endfunction : issue_accepted

    // ------------------------------------------------------------
    // Range and flag functions
    // ------------------------------------------------------------

    function automatic logic [63:0] sext32(input logic [31:0] v);
        sext32 = {{32{v[31]}}, v};
    endfunction : sext32

    function automatic logic above_q31(input logic [63:0] v);
        above_q31 = !v[63]
            && (v[QMAC_Q31_HI:QMAC_Q31_LO] != QMAC_MASK_ZERO);
    endfunction : above_q31

    function automatic logic below_q31(input logic [63:0] v);
        below_q31 = v[63]
            && (v[QMAC_Q31_HI:QMAC_Q31_LO] != QMAC_MASK_ONES);
    endfunction : below_q31

    function automatic logic [63:0] q31_clamp(input logic [63:0] v);
        if (above_q31(v)) begin
            q31_clamp = QMAC_ACC_POS_MAX;
        end else if (below_q31(v)) begin
            q31_clamp = QMAC_ACC_NEG_MIN;
        end else begin
            q31_clamp = v;
        end
    endfunction : q31_clamp

    function automatic logic [3:0] merge_flags(input logic [3:0] old,
        input logic [3:0] mask);
        merge_flags = old | mask;
    endfunction : merge_flags

    // ------------------------------------------------------------
    // Word split functions
    // ------------------------------------------------------------

    function automatic logic [31:0] acc_high(input logic [63:0] v);
        acc_high = v[63:32];
    endfunction : acc_high

    function automatic logic [31:0] acc_low(input logic [63:0] v);
        acc_low = v[31:0];
    endfunction : acc_low

    // ------------------------------------------------------------
    // Accumulator state
    // ------------------------------------------------------------

    logic [63:0] acc [QMAC_NUM_ACC];
    logic [63:0] next_acc [QMAC_NUM_ACC];

    // ------------------------------------------------------------
    // Control state
    // ------------------------------------------------------------

    logic [31:0] ctrl;
    logic [31:0] next_ctrl;

    // ------------------------------------------------------------
    // Completion state
    // ------------------------------------------------------------

    logic done_q;
    logic next_done;
    qmac_exc_s exc_q;
    qmac_exc_s next_exc;

    // ------------------------------------------------------------
    // Operand signals
    // ------------------------------------------------------------

    logic is_left;
    logic is_full;
    logic [15:0] half_s;
    logic [15:0] half_t;
    logic [31:0] product;
    logic product_sat;

    // ------------------------------------------------------------
    // Sum signals
    // ------------------------------------------------------------

    logic [63:0] acc_in;
    logic [63:0] sum;
    logic [63:0] result;
    logic clamp_pos;
    logic clamp_neg;
    logic clamp;

    // ------------------------------------------------------------
    // Issue signals
    // ------------------------------------------------------------

    logic go;
    logic refuse_reserved;
    logic refuse_disabled;
    logic flag_event;
    logic [3:0] write_mask;

    // ------------------------------------------------------------
    // Issue decode
    // ------------------------------------------------------------

    always_comb begin
        is_left = op_is_left(req.op);
        is_full = op_is_full(req.op);
        half_s = pick_half(req.src_s, is_left);
        half_t = pick_half(req.src_t, is_left);
    end

    always_comb begin
        // Exceptions depend on valid, the opcode and enable only, not on data.
        refuse_reserved = 1'b0;
        refuse_disabled = 1'b0;
        if (req.valid) begin
            if (opcode_reserved) begin
                refuse_reserved = 1'b1;
            end else if (!signal_proc_enable) begin
                refuse_disabled = 1'b1;
            end
        end
        go = issue_accepted(req.valid, opcode_reserved,
            signal_proc_enable);
        write_mask = go ? acc_mask(req.accumulator_select)
            : 4'h0;
    end

    // ------------------------------------------------------------
    // Product
    // ------------------------------------------------------------

    qmac_product u_product (
        .half_s(half_s),
        .half_t(half_t),
        .product(product),
        .product_sat(product_sat)
    );

    // ------------------------------------------------------------
    // Accumulate and clamp
    // ------------------------------------------------------------

    always_comb begin
        acc_in = acc[req.accumulator_select];
        sum = acc_in + sext32(product);
        clamp_pos = is_full && above_q31(sum);
        clamp_neg = is_full && below_q31(sum);
        clamp = clamp_pos || clamp_neg;
        if (is_full) begin
            result = q31_clamp(sum);
        end else begin
            result = sum;
        end
        flag_event = go
            && (product_sat || clamp);
    end

    // ------------------------------------------------------------
    // Accumulator file
    // ------------------------------------------------------------

    always_comb begin
        for (int i = 0; i < QMAC_NUM_ACC; i++) begin
            if (reset) begin
                next_acc[i] = QMAC_ACC_RESET;
            end else if (write_mask[i]) begin
                next_acc[i] = result;
            end else begin
                next_acc[i] = acc[i];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        acc <= next_acc;
    end

    // ------------------------------------------------------------
    // Control register flags
    // ------------------------------------------------------------

    always_comb begin
        next_ctrl = ctrl;
        if (reset) begin
            next_ctrl = QMAC_CTRL_RESET;
        end else if (flag_event) begin
            // Only the selected bit is set; only reset clears the field.
            next_ctrl[QMAC_FLAG_MSB:QMAC_FLAG_LSB] = merge_flags(
                ctrl[QMAC_FLAG_MSB:QMAC_FLAG_LSB],
                write_mask);
        end
    end

    always_ff @(posedge sys_clk) begin
        ctrl <= next_ctrl;
    end

    // ------------------------------------------------------------
    // Completion and exceptions
    // ------------------------------------------------------------

    always_comb begin
        if (reset) begin
            next_done = 1'b0;
            next_exc = '0;
        end else begin
            next_done = go;
            next_exc.reserved_instr = refuse_reserved;
            next_exc.signal_proc_disabled = refuse_disabled;
        end
    end

    always_ff @(posedge sys_clk) begin
        done_q <= next_done;
        exc_q <= next_exc;
    end

    // ------------------------------------------------------------
    // Accumulator outputs
    // ------------------------------------------------------------

    always_comb begin
        for (int i = 0; i < QMAC_NUM_ACC; i++) begin
            accumulator_high_word[i] = acc_high(acc[i]);
        end
    end

    always_comb begin
        for (int i = 0; i < QMAC_NUM_ACC; i++) begin
            accumulator_low_word[i] = acc_low(acc[i]);
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------

    assign done = done_q;
    assign exc = exc_q;
    assign signal_proc_control_reg = ctrl;

endmodule : qmac_unit
`default_nettype wire

// >>> sim/qmac_unit_chk_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module qmac_unit_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire qmac_pkg::qmac_req_s req,
    input wire logic signal_proc_enable,
    input wire logic opcode_reserved,
    input wire logic done,
    input wire qmac_pkg::qmac_exc_s exc,
    input wire logic [31:0] signal_proc_control_reg
);
    import qmac_pkg::*;
    wire logic ok = req.valid && !opcode_reserved && signal_proc_enable;
    wire logic [3:0] fl = signal_proc_control_reg[19:16];
    wire logic [3:0] sm = 4'h1 << req.accumulator_select;
    wire logic [15:0] s = req.op[1] ? req.src_s[15:0] : req.src_s[31:16];
    wire logic [15:0] t = req.op[1] ? req.src_t[15:0] : req.src_t[31:16];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_bad; req.valid && !ok; endsequence
    property p_done; ok |=> done && exc == 2'b00; endproperty
    a_done: assert property (p_done) else $error("no done");
    property p_res; req.valid && opcode_reserved |=> exc == 2'b10; endproperty
    a_res: assert property (p_res) else $error("no reserved");
    property p_dis; s_bad ##0 !opcode_reserved |=> exc == 2'b01; endproperty
    a_dis: assert property (p_dis) else $error("no disabled");
    property p_keep; s_bad |=> !done && $stable(fl); endproperty
    a_keep: assert property (p_keep)
        else $error("refused op acted");
    property p_idle; !req.valid |=> !done && exc == 2'b00; endproperty
    a_idle: assert property (p_idle)
        else $error("spurious result");
    property p_stk; !$past(reset) |-> (~fl & $past(fl)) == 4'h0; endproperty
    a_stk: assert property (p_stk) else $error("flag cleared");
    property p_sat; ok && s == 16'h8000 && t == 16'h8000 |=> |(fl & $past(sm));
    endproperty
    a_sat: assert property (p_sat) else $error("no sat flag");
    property p_oth; ok |=> (fl & ~$past(sm)) == ($past(fl) & ~$past(sm));
    endproperty
    a_oth: assert property (p_oth) else $error("wrong flag");
endmodule : qmac_unit_chk
bind qmac_unit qmac_unit_chk u_chk (.*);
`default_nettype wire

// >>> sim/qmac_pipe_model.sv
`timescale 1ns/10ps
`default_nettype none
module qmac_pipe_model (
    input wire logic sys_clk,
    output var qmac_pkg::qmac_req_s req
);
    import qmac_pkg::*;
    initial req = '0;
    task automatic issue(input qmac_op_e op, input logic [1:0] sel,
        input logic [31:0] s, t);
        @(posedge sys_clk);
        #1 req = '{1'b1, op, sel, s, t};
        @(posedge sys_clk);
        #1 req = {1'b0, ~req[67:0]};
    endtask : issue
endmodule : qmac_pipe_model
`default_nettype wire

// >>> sim/qmac_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module qmac_unit_tb;
    import qmac_pkg::*;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic signal_proc_enable = 1'b1;
    logic opcode_reserved = 1'b0;
    qmac_req_s req;
    logic done;
    qmac_exc_s exc;
    logic [31:0] ctrl;
    logic [31:0] hi [4];
    logic [31:0] lo [4];
    logic [63:0] acc [4] = '{default: '0};
    logic [3:0] flags = 4'h0;
    int n_fail = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 sys_clk = ~sys_clk;
    qmac_pipe_model u_pipe (.sys_clk(sys_clk), .req(req));
    qmac_unit DUT (.sys_clk(sys_clk), .reset(reset), .req(req),
        .signal_proc_enable(signal_proc_enable),
        .opcode_reserved(opcode_reserved), .done(done), .exc(exc),
        .signal_proc_control_reg(ctrl), .accumulator_high_word(hi),
        .accumulator_low_word(lo));
    task automatic print_verdict;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    task automatic cmp(input string nm, input logic [63:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : cmp
    task automatic run(input qmac_op_e op, input logic [1:0] sel,
        input logic [31:0] s, t);
        logic [15:0] hs;
        logic [15:0] ht;
        logic signed [63:0] p;
        logic ok;
        logic sat;
        ok = !opcode_reserved && signal_proc_enable;
        hs = op[1] ? s[15:0] : s[31:16];
        ht = op[1] ? t[15:0] : t[31:16];
        sat = hs == 16'h8000 && ht == 16'h8000;
        p = $signed(hs) * $signed(ht);
        p = (sat ? 64'h7fffffff : p <<< 1) + acc[sel];
        if (op[0] && p[62:31] != {32{p[63]}}) begin
            p = p[63] ? 64'hffffffff80000000 : 64'h7fffffff;
            sat = 1'b1;
        end
        if (ok) begin
            acc[sel] = p;
            flags[sel] = flags[sel] | sat;
        end
        u_pipe.issue(op, sel, s, t);
        cmp("done", done, ok);
        cmp("exc", exc,
            {opcode_reserved, !ok && !opcode_reserved});
        cmp("acc", {hi[sel], lo[sel]}, acc[sel]);
        cmp("acc_hi", hi[sel], acc[sel][63:32]);
        for (int i = 0; i < 4; i++) begin
            cmp("accs", {hi[i], lo[i]}, acc[i]);
        end
        cmp("ctrl", ctrl, {12'h0, flags, 16'h0});
        cmp("flags", ctrl[19:16], flags);
    endtask : run
    task automatic t_mult;
        run(QMAC_LEFT_PRODUCT_SAT, 2'h0, 32'h40001234, 32'hc0005678);
        run(QMAC_RIGHT_PRODUCT_SAT, 2'h1, 32'h12348000, 32'h56787fff);
        $display("mult test end");
    endtask : t_mult
    task automatic t_sat;
        for (int i = 0; i < 3; i++) begin
            run(QMAC_LEFT_FULL_SAT, 2'h2, 32'h80000000, 32'h80000000);
            run(QMAC_RIGHT_PRODUCT_SAT, 2'h3, 32'h00008000, 32'h00008000);
        end
        $display("sat test end");
    endtask : t_sat
    task automatic t_clamp;
        for (int i = 0; i < 3; i++) begin
            run(QMAC_LEFT_FULL_SAT, 2'h0, 32'h80000000, 32'h7fff0000);
            run(QMAC_RIGHT_FULL_SAT, 2'h1, 32'h00007fff, 32'h00007fff);
        end
        $display("clamp test end");
    endtask : t_clamp
    task automatic t_refuse;
        opcode_reserved = 1'b1;
        run(QMAC_LEFT_PRODUCT_SAT, 2'h3, 32'h80000000, 32'h80000000);
        signal_proc_enable = 1'b0;
        run(QMAC_RIGHT_FULL_SAT, 2'h1, 32'h00008000, 32'h00008000);
        opcode_reserved = 1'b0;
        run(QMAC_LEFT_FULL_SAT, 2'h0, 32'h80000000, 32'h80000000);
        signal_proc_enable = 1'b1;
        run(QMAC_RIGHT_PRODUCT_SAT, 2'h1, 32'h00001000, 32'h00002000);
        $display("refuse test end");
    endtask : t_refuse
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 400) begin
            n_fail++;
            print_verdict;
        end
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_mult;
        t_sat;
        t_clamp;
        t_refuse;
        print_verdict;
    end
endmodule : qmac_unit_tb
`default_nettype wire
